// File: hw/tcc_pkg.sv
// constants for the timer compare, capture and interrupt block
package tcc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CMP_A_LO   = 8'h00;
  localparam logic [7:0] ADDR_CMP_A_HI   = 8'h04;
  localparam logic [7:0] ADDR_CMP_B_LO   = 8'h08;
  localparam logic [7:0] ADDR_CMP_B_HI   = 8'h0c;
  localparam logic [7:0] ADDR_CMP_C_LO   = 8'h10;
  localparam logic [7:0] ADDR_CMP_C_HI   = 8'h14;
  localparam logic [7:0] ADDR_CAPT_LO    = 8'h18;
  localparam logic [7:0] ADDR_CAPT_HI    = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h20;
  localparam logic [7:0] ADDR_IRQ_FLAGS  = 8'h24;
  localparam logic [7:0] ADDR_CTRL       = 8'h28;
  // interrupt bit positions
  localparam int BIT_OVF  = 0;
  localparam int BIT_CMPA = 1;
  localparam int BIT_CMPB = 2;
  localparam int BIT_CMPC = 3;
  localparam int BIT_CAPT = 5;
  localparam logic [7:0] MASK_IMPL  = 8'h2f;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  // control register fields
  localparam int CTRL_GIE = 0;
  localparam int CTRL_ACO = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // waveform modes; the first four use capture_value as top
  localparam logic [3:0] WGM_PFC_CAPT  = 4'h8;
  localparam logic [3:0] WGM_PC_CAPT   = 4'ha;
  localparam logic [3:0] WGM_CTC_CAPT  = 4'hc;
  localparam logic [3:0] WGM_FAST_CAPT = 4'he;
  localparam logic [3:0] WGM_NORMAL    = 4'h0;
  localparam logic [3:0] WGM_CTC_A     = 4'h4;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {TCC_IDLE, TCC_WRESP, TCC_RRESP} tcc_bus_state_t;
endpackage

// File: hw/tcc_match.sv
// one compare channel: equality test and registered match flag
`timescale 1ns/1ps
`default_nettype none
module tcc_match (
  input  wire logic        clock_in,    // timer clock
  input  wire logic        rst_in,      // sync reset
  input  wire logic [15:0] counter_in,  // counter value
  input  wire logic [15:0] compare_in,  // compare value
  input  wire logic        block_in,    // suppress after counter write
  output var  logic        match_out    // registered match, one cycle later
);
  logic match_q;
  logic match_d;
  always_comb begin
    match_d = (counter_in == compare_in) && !block_in;
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_d;
    end
  end
  assign match_out = match_q;
endmodule
`default_nettype wire

// File: hw/tcc_capture.sv
// capture edge detection and capture register
`timescale 1ns/1ps
`default_nettype none
module tcc_capture (
  input  wire logic        clock_in,    // timer clock
  input  wire logic        rst_in,      // sync reset
  input  wire logic        event_in,    // selected capture source level
  input  wire logic        rising_in,   // 1 rising edge, 0 falling edge
  input  wire logic        enable_in,   // capture allowed (not used as top)
  input  wire logic [15:0] counter_in,  // counter value
  output var  logic [15:0] value_out,   // capture_value
  output var  logic        event_out    // capture happened, one cycle pulse
);
  logic        prev_q, prev_d, ev_q, ev_d;
  logic [15:0] val_q, val_d;
  logic        edge_hit;
  always_comb begin
    edge_hit = rising_in ? (event_in && !prev_q) : (!event_in && prev_q);
    prev_d   = event_in;
    ev_d     = edge_hit && enable_in;
    val_d    = ev_d ? counter_in : val_q;
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prev_q <= 1'b0;
      ev_q   <= 1'b0;
      val_q  <= 16'h0000;
    end else begin
      prev_q <= prev_d;
      ev_q   <= ev_d;
      val_q  <= val_d;
    end
  end
  assign value_out = val_q;
  assign event_out = ev_q;
endmodule
`default_nettype wire

// File: hw/tcc_top.sv
// timer compare, capture and interrupt block with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module tcc_top
  import tcc_pkg::*;
(
  input  wire logic        clock_in,         // 20 MHz clock
  input  wire logic        rst_in,           // sync reset, active high
  input  wire logic [7:0]  s_axi_awaddr,     // write address
  input  wire logic        s_axi_awvalid,    // write address valid
  output var  logic        s_axi_awready,    // write address ready
  input  wire logic [31:0] s_axi_wdata,      // write data
  input  wire logic [3:0]  s_axi_wstrb,      // write strobes
  input  wire logic        s_axi_wvalid,     // write data valid
  output var  logic        s_axi_wready,     // write data ready
  output var  logic [1:0]  s_axi_bresp,      // write response
  output var  logic        s_axi_bvalid,     // write response valid
  input  wire logic        s_axi_bready,     // write response ready
  input  wire logic [7:0]  s_axi_araddr,     // read address
  input  wire logic        s_axi_arvalid,    // read address valid
  output var  logic        s_axi_arready,    // read address ready
  output var  logic [31:0] s_axi_rdata,      // read data
  output var  logic [1:0]  s_axi_rresp,      // read response
  output var  logic        s_axi_rvalid,     // read data valid
  input  wire logic        s_axi_rready,     // read data ready
  input  wire logic [15:0] counter_value_in, // running counter
  input  wire logic        counter_write_in, // cpu wrote the counter
  input  wire logic        overflow_in,      // counter overflow event
  input  wire logic        top_reached_in,   // counter reached top
  input  wire logic [3:0]  waveform_mode_field_in, // waveform mode
  input  wire logic        capture_input_pin_in,   // capture pin
  input  wire logic        comparator_in,    // analog comparator output
  input  wire logic        capture_rising_in,// capture edge select
  input  wire logic        force_match_a_in, // forced compare strobe a
  input  wire logic        force_match_b_in, // forced compare strobe b
  input  wire logic        force_match_c_in, // forced compare strobe c
  input  wire logic [7:0]  irq_ack_in,       // vector acknowledge per flag bit
  output var  logic [2:0]  match_out,        // compare match a,b,c (with force)
  output var  logic [15:0] compare_value_a_out, // compare a value
  output var  logic [15:0] compare_value_b_out, // compare b value
  output var  logic [15:0] compare_value_c_out, // compare c value
  output var  logic [15:0] capture_top_out,  // capture value as top
  output var  logic        capture_is_top_out, // mode uses capture as top
  output var  logic [7:0]  irq_req_out,      // request per source
  output var  logic        irq_out           // any unmasked request
);
  tcc_bus_state_t st_q, st_d;
  logic [15:0] cmp_q [3];
  logic [15:0] cmp_d [3];
  logic [7:0]  hi_latch_q, hi_latch_d;
  logic [7:0]  mask_q, mask_d, flags_q, flags_d;
  logic [1:0]  ctrl_q, ctrl_d;
  logic [7:0]  aw_q, aw_d;
  logic [31:0] wd_q, wd_d, rdata_q, rdata_d;
  logic [3:0]  ws_q, ws_d;
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:0]  req_q, req_d;
  logic        irq_q, irq_d, cap_top_q, cap_top_d;
  logic [2:0]  mh, fm_q, fm_d;
  logic [15:0] cap_val;
  logic        cap_ev, cap_top_mode;
  logic [7:0]  set_ev;
  logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;

  assign cap_top_mode = (waveform_mode_field_in == WGM_PFC_CAPT)
                     || (waveform_mode_field_in == WGM_PC_CAPT)
                     || (waveform_mode_field_in == WGM_CTC_CAPT)
                     || (waveform_mode_field_in == WGM_FAST_CAPT);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_match
      tcc_match u_match (
        .clock_in   (clock_in),
        .rst_in     (rst_in),
        .counter_in (counter_value_in),
        .compare_in (cmp_q[g]),
        .block_in   (counter_write_in),
        .match_out  (mh[g])
      );
    end
  endgenerate

  tcc_capture u_capture (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .event_in   (ctrl_q[CTRL_ACO] ? comparator_in : capture_input_pin_in),
    .rising_in  (capture_rising_in),
    .enable_in  (!cap_top_mode),
    .counter_in (counter_value_in),
    .value_out  (cap_val),
    .event_out  (cap_ev)
  );

  // hardware events; forced strobes only reach the waveform path
  always_comb begin
    set_ev           = 8'h00;
    set_ev[BIT_CMPA] = mh[0];
    set_ev[BIT_CMPB] = mh[1];
    set_ev[BIT_CMPC] = mh[2];
    set_ev[BIT_CAPT] = cap_top_mode ? top_reached_in : cap_ev;
    set_ev[BIT_OVF]  = overflow_in;
    fm_d = mh | {force_match_c_in, force_match_b_in, force_match_a_in};
    cap_top_d = cap_top_mode;
  end

  // axi4-lite slave, one write and one read at a time
  always_comb begin
    st_d       = st_q;
    aw_d       = aw_q;
    wd_d       = wd_q;
    ws_d       = ws_q;
    aw_have_d  = aw_have_q;
    w_have_d   = w_have_q;
    bresp_d    = bresp_q;
    rresp_d    = rresp_q;
    rdata_d    = rdata_q;
    cmp_d      = cmp_q;
    hi_latch_d = hi_latch_q;
    mask_d     = mask_q;
    ctrl_d     = ctrl_q;
    flags_d    = flags_q;
    if (s_axi_awvalid && awready_q) begin
      aw_d      = s_axi_awaddr;
      aw_have_d = 1'b1;
    end
    if (s_axi_wvalid && wready_q) begin
      wd_d     = s_axi_wdata;
      ws_d     = s_axi_wstrb;
      w_have_d = 1'b1;
    end
    case (st_q)
      TCC_IDLE: begin
        if (aw_have_q && w_have_q) begin
          bresp_d = AXI_OKAY;
          if (ws_q[0]) begin
            if (aw_q == ADDR_CMP_A_HI || aw_q == ADDR_CMP_B_HI
                || aw_q == ADDR_CMP_C_HI) begin
              hi_latch_d = wd_q[7:0];
            end else if (aw_q == ADDR_CMP_A_LO) begin
              cmp_d[0] = {hi_latch_q, wd_q[7:0]};
            end else if (aw_q == ADDR_CMP_B_LO) begin
              cmp_d[1] = {hi_latch_q, wd_q[7:0]};
            end else if (aw_q == ADDR_CMP_C_LO) begin
              cmp_d[2] = {hi_latch_q, wd_q[7:0]};
            end else if (aw_q == ADDR_IRQ_MASK) begin
              mask_d = wd_q[7:0] & MASK_IMPL;
            end else if (aw_q == ADDR_IRQ_FLAGS) begin
              flags_d = flags_q & ~(wd_q[7:0] & MASK_IMPL);
            end else if (aw_q == ADDR_CTRL) begin
              ctrl_d = wd_q[1:0];
            end else if (aw_q == ADDR_CAPT_LO || aw_q == ADDR_CAPT_HI) begin
              bresp_d = AXI_OKAY;
            end else begin
              bresp_d = AXI_SLVERR;
            end
          end
          aw_have_d = 1'b0;
          w_have_d  = 1'b0;
          st_d      = TCC_WRESP;
        end else if (s_axi_arvalid && arready_q) begin
          rresp_d = AXI_OKAY;
          rdata_d = 32'h0000_0000;
          if (s_axi_araddr == ADDR_CMP_A_LO) begin
            rdata_d[7:0] = cmp_q[0][7:0];
          end else if (s_axi_araddr == ADDR_CMP_A_HI) begin
            rdata_d[7:0] = cmp_q[0][15:8];
          end else if (s_axi_araddr == ADDR_CMP_B_LO) begin
            rdata_d[7:0] = cmp_q[1][7:0];
          end else if (s_axi_araddr == ADDR_CMP_B_HI) begin
            rdata_d[7:0] = cmp_q[1][15:8];
          end else if (s_axi_araddr == ADDR_CMP_C_LO) begin
            rdata_d[7:0] = cmp_q[2][7:0];
          end else if (s_axi_araddr == ADDR_CMP_C_HI) begin
            rdata_d[7:0] = cmp_q[2][15:8];
          end else if (s_axi_araddr == ADDR_CAPT_LO) begin
            rdata_d[7:0] = cap_val[7:0];
            hi_latch_d   = cap_val[15:8];
          end else if (s_axi_araddr == ADDR_CAPT_HI) begin
            rdata_d[7:0] = hi_latch_q;
          end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
            rdata_d[7:0] = mask_q;
          end else if (s_axi_araddr == ADDR_IRQ_FLAGS) begin
            rdata_d[7:0] = flags_q;
          end else if (s_axi_araddr == ADDR_CTRL) begin
            rdata_d[1:0] = ctrl_q;
          end else begin
            rresp_d = AXI_SLVERR;
          end
          st_d = TCC_RRESP;
        end
      end
      TCC_WRESP: begin
        if (s_axi_bready) begin
          st_d = TCC_IDLE;
        end
      end
      TCC_RRESP: begin
        if (s_axi_rready) begin
          st_d = TCC_IDLE;
        end
      end
      default: begin
        st_d = TCC_IDLE;
      end
    endcase
    // acknowledge clears, then hardware set wins
    flags_d = (flags_d & ~irq_ack_in) | (set_ev & MASK_IMPL);
    // handshake outputs registered from the next state
    awready_d = (st_d == TCC_IDLE) && !aw_have_d;
    wready_d  = (st_d == TCC_IDLE) && !w_have_d;
    arready_d = (st_d == TCC_IDLE) && !(aw_have_d && w_have_d);
    bvalid_d  = (st_d == TCC_WRESP);
    rvalid_d  = (st_d == TCC_RRESP);
  end

  always_comb begin
    req_d = flags_q & mask_q & {8{ctrl_q[CTRL_GIE]}};
    irq_d = |req_d;
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_q       <= TCC_IDLE;
      aw_q       <= 8'h00;
      wd_q       <= 32'h0000_0000;
      ws_q       <= 4'h0;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      bresp_q    <= AXI_OKAY;
      rresp_q    <= AXI_OKAY;
      rdata_q    <= 32'h0000_0000;
      cmp_q[0]   <= CMP_RESET;
      cmp_q[1]   <= CMP_RESET;
      cmp_q[2]   <= CMP_RESET;
      hi_latch_q <= 8'h00;
      mask_q     <= MASK_RESET;
      flags_q    <= FLAG_RESET;
      ctrl_q     <= CTRL_RESET;
      req_q      <= 8'h00;
      irq_q      <= 1'b0;
      fm_q       <= 3'h0;
      cap_top_q  <= 1'b0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      arready_q  <= 1'b0;
      bvalid_q   <= 1'b0;
      rvalid_q   <= 1'b0;
    end else begin
      st_q       <= st_d;
      aw_q       <= aw_d;
      wd_q       <= wd_d;
      ws_q       <= ws_d;
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      bresp_q    <= bresp_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
      cmp_q      <= cmp_d;
      hi_latch_q <= hi_latch_d;
      mask_q     <= mask_d;
      flags_q    <= flags_d;
      ctrl_q     <= ctrl_d;
      req_q      <= req_d;
      irq_q      <= irq_d;
      fm_q       <= fm_d;
      cap_top_q  <= cap_top_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      arready_q  <= arready_d;
      bvalid_q   <= bvalid_d;
      rvalid_q   <= rvalid_d;
    end
  end

  assign s_axi_awready       = awready_q;
  assign s_axi_wready        = wready_q;
  assign s_axi_bvalid        = bvalid_q;
  assign s_axi_bresp         = bresp_q;
  assign s_axi_arready       = arready_q;
  assign s_axi_rvalid        = rvalid_q;
  assign s_axi_rdata         = rdata_q;
  assign s_axi_rresp         = rresp_q;
  assign match_out           = fm_q;
  assign compare_value_a_out = cmp_q[0];
  assign compare_value_b_out = cmp_q[1];
  assign compare_value_c_out = cmp_q[2];
  assign capture_top_out     = cap_val;
  assign capture_is_top_out  = cap_top_q;
  assign irq_req_out         = req_q;
  assign irq_out             = irq_q;
endmodule
`default_nettype wire

// File: test/tcc_top_sva.sv
// assertion checker for the timer compare, capture and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tcc_top_sva (
  input  wire logic        clock_in,               // clock
  input  wire logic        rst_in,                 // sync reset
  input  wire logic        s_axi_bvalid,           // write response valid
  input  wire logic        s_axi_bready,           // write response ready
  input  wire logic [1:0]  s_axi_bresp,            // write response
  input  wire logic        s_axi_arvalid,          // read address valid
  input  wire logic        s_axi_arready,          // read address ready
  input  wire logic        s_axi_rvalid,           // read data valid
  input  wire logic        s_axi_rready,           // read data ready
  input  wire logic [31:0] s_axi_rdata,            // read data
  input  wire logic [15:0] counter_value_in,       // counter
  input  wire logic        counter_write_in,       // counter written
  input  wire logic        force_match_a_in,       // forced compare a
  input  wire logic [15:0] compare_value_a_out,    // compare a value
  input  wire logic [2:0]  match_out,              // match a,b,c
  input  wire logic [3:0]  waveform_mode_field_in, // mode
  input  wire logic        capture_is_top_out,     // capture as top
  input  wire logic [7:0]  irq_req_out,            // requests
  input  wire logic        irq_out                 // interrupt
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped before rready");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  AST_MATCH_A: assert property (
    counter_value_in == compare_value_a_out && $stable(compare_value_a_out) && !counter_write_in
    |=> ##1 match_out[0]) else $error("equal counter gave no match on channel a");
  AST_MATCH_BLOCK: assert property (
    counter_write_in ##1 !force_match_a_in |=> !match_out[0])
    else $error("match not blocked after counter write");
  AST_CAPT_TOP: assert property (
    1'b1 |=> capture_is_top_out == ($past(waveform_mode_field_in) inside {4'h8, 4'ha, 4'hc, 4'he}))
    else $error("capture top indication wrong for mode");
  AST_REQ_RSVD: assert property (irq_req_out[7:6] == 2'h0 && !irq_req_out[4])
    else $error("request on an unused source");
  AST_IRQ_LOW: assert property (irq_req_out == 8'h00 ##1 irq_req_out == 8'h00 |-> !irq_out)
    else $error("interrupt high without request");
  AST_IRQ_HIGH: assert property (irq_req_out != 8'h00 ##1 irq_req_out != 8'h00 |-> irq_out)
    else $error("interrupt low with request pending");
endmodule

bind tcc_top tcc_top_sva u_sva (.clock_in(clock_in), .rst_in(rst_in),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .counter_value_in(counter_value_in),
  .counter_write_in(counter_write_in), .force_match_a_in(force_match_a_in),
  .compare_value_a_out(compare_value_a_out), .match_out(match_out),
  .waveform_mode_field_in(waveform_mode_field_in), .capture_is_top_out(capture_is_top_out),
  .irq_req_out(irq_req_out), .irq_out(irq_out));
`default_nettype wire

// File: test/tcc_top_bench.sv
// self-checking bench for the timer compare, capture and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tcc_top_bench;
  import tcc_pkg::*;
  logic        clock_in = 1'b0, rst_in = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        counter_write_in = 1'b0, overflow_in = 1'b0, top_reached_in = 1'b0;
  logic        capture_input_pin_in = 1'b0, comparator_in = 1'b0, capture_rising_in = 1'b1;
  logic        force_match_a_in = 1'b0, force_match_b_in = 1'b0, force_match_c_in = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, irq_ack_in = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf, waveform_mode_field_in = 4'h0;
  logic [15:0] counter_value_in = 16'hfff0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        irq_out, capture_is_top_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0]  match_out;
  logic [15:0] compare_value_a_out, compare_value_b_out, compare_value_c_out, capture_top_out;
  logic [7:0]  irq_req_out;
  int          n_errors = 0;
  int          compares = 0;

  tcc_top dut (.clock_in(clock_in), .rst_in(rst_in), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .counter_value_in(counter_value_in),
    .counter_write_in(counter_write_in), .overflow_in(overflow_in),
    .top_reached_in(top_reached_in), .waveform_mode_field_in(waveform_mode_field_in),
    .capture_input_pin_in(capture_input_pin_in), .comparator_in(comparator_in),
    .capture_rising_in(capture_rising_in), .force_match_a_in(force_match_a_in),
    .force_match_b_in(force_match_b_in), .force_match_c_in(force_match_c_in),
    .irq_ack_in(irq_ack_in), .match_out(match_out), .compare_value_a_out(compare_value_a_out),
    .compare_value_b_out(compare_value_b_out), .compare_value_c_out(compare_value_c_out),
    .capture_top_out(capture_top_out), .capture_is_top_out(capture_is_top_out),
    .irq_req_out(irq_req_out), .irq_out(irq_out));

  always #25 clock_in = ~clock_in;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: response %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // write both channels, release each when taken, wait for the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk_resp(s_axi_bresp, er);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk_resp(s_axi_rresp, er);
    if (er === AXI_OKAY) chk(s_axi_rdata, ed);
  endtask

  task automatic cnt(input logic [15:0] v, input logic w);
    counter_value_in <= v;
    counter_write_in <= w;
    @(posedge clock_in);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    cyc(5);
    rst_in <= 1'b0;
    for (int i = 0; i < 6; i++) rchk(8'(i * 4), 32'(CMP_RESET[7:0]), AXI_OKAY);
    rchk(ADDR_IRQ_MASK, 32'(MASK_RESET), AXI_OKAY);
    rchk(ADDR_IRQ_FLAGS, 32'(FLAG_RESET), AXI_OKAY);
    rchk(8'h2c, 32'h0, AXI_SLVERR);
    wr(8'h2c, 32'h0, AXI_SLVERR);
    $display("test reset values done");
    wr(ADDR_CMP_A_HI, 32'h12, AXI_OKAY);
    cyc(2);
    chk(32'(compare_value_a_out), 32'h0);
    wr(ADDR_CMP_A_LO, 32'h34, AXI_OKAY);
    wr(ADDR_CMP_B_HI, 32'hab, AXI_OKAY);
    wr(ADDR_CMP_B_LO, 32'h01, AXI_OKAY);
    wr(ADDR_CMP_C_LO, 32'h78, AXI_OKAY); // high byte still held in the shared latch
    cyc(2);
    chk(32'(compare_value_a_out), 32'h1234);
    chk(32'(compare_value_b_out), 32'hab01);
    chk(32'(compare_value_c_out), 32'hab78);
    rchk(ADDR_CMP_A_HI, 32'h12, AXI_OKAY);
    $display("test paired writes done");
    wr(ADDR_IRQ_MASK, 32'hff, AXI_OKAY);
    rchk(ADDR_IRQ_MASK, 32'(MASK_IMPL), AXI_OKAY);
    wr(ADDR_CTRL, 32'h1, AXI_OKAY);
    cnt(16'h1234, 1'b0);
    cnt(16'hab01, 1'b0);
    cnt(16'hab78, 1'b0);
    cnt(16'hfff0, 1'b0);
    cyc(4);
    rchk(ADDR_IRQ_FLAGS, 32'h0e, AXI_OKAY);
    chk(32'(irq_req_out), 32'h0e);
    wr(ADDR_IRQ_MASK, 32'h2b, AXI_OKAY);
    cyc(3);
    chk(32'(irq_req_out), 32'h0a);
    chk(32'(irq_out), 32'h1);
    wr(ADDR_CTRL, 32'h0, AXI_OKAY);
    cyc(3);
    chk(32'(irq_out), 32'h0);
    wr(ADDR_IRQ_FLAGS, 32'h0, AXI_OKAY);
    rchk(ADDR_IRQ_FLAGS, 32'h0e, AXI_OKAY);
    wr(ADDR_IRQ_FLAGS, 32'h02, AXI_OKAY);
    rchk(ADDR_IRQ_FLAGS, 32'h0c, AXI_OKAY);
    irq_ack_in <= 8'h08;
    cyc(1);
    irq_ack_in <= 8'h00;
    rchk(ADDR_IRQ_FLAGS, 32'h04, AXI_OKAY);
    wr(ADDR_IRQ_FLAGS, 32'h04, AXI_OKAY);
    $display("test matches and flags done");
    wr(ADDR_CTRL, 32'h1, AXI_OKAY);
    force_match_a_in <= 1'b1;
    force_match_b_in <= 1'b1;
    force_match_c_in <= 1'b1;
    cyc(1);
    force_match_a_in <= 1'b0;
    force_match_b_in <= 1'b0;
    force_match_c_in <= 1'b0;
    cnt(16'h1234, 1'b1); // counter write hides this match
    chk(32'(match_out), 32'h7);
    cnt(16'hfff0, 1'b0);
    cyc(4);
    rchk(ADDR_IRQ_FLAGS, 32'h0, AXI_OKAY);
    chk(32'(irq_req_out), 32'h0);
    overflow_in <= 1'b1;
    cyc(1);
    overflow_in <= 1'b0;
    cyc(3);
    rchk(ADDR_IRQ_FLAGS, 32'h01, AXI_OKAY);
    chk(32'(irq_req_out), 32'h01);
    wr(ADDR_IRQ_FLAGS, 32'h01, AXI_OKAY);
    $display("test force, counter write, overflow done");
    counter_value_in <= 16'h9abc;
    capture_input_pin_in <= 1'b1;
    cyc(3);
    rchk(ADDR_IRQ_FLAGS, 32'h20, AXI_OKAY);
    rchk(ADDR_CAPT_LO, 32'hbc, AXI_OKAY);
    counter_value_in <= 16'h1111;
    capture_input_pin_in <= 1'b0;
    cyc(1);
    capture_input_pin_in <= 1'b1;
    cyc(3);
    rchk(ADDR_CAPT_HI, 32'h9a, AXI_OKAY);
    rchk(ADDR_CAPT_LO, 32'h11, AXI_OKAY);
    capture_rising_in <= 1'b0;
    counter_value_in <= 16'h5566;
    capture_input_pin_in <= 1'b0;
    cyc(3);
    rchk(ADDR_CAPT_LO, 32'h66, AXI_OKAY);
    capture_rising_in <= 1'b1;
    wr(ADDR_CTRL, 32'h3, AXI_OKAY);
    counter_value_in <= 16'h4242;
    comparator_in <= 1'b1;
    cyc(3);
    rchk(ADDR_CAPT_LO, 32'h42, AXI_OKAY);
    wr(ADDR_IRQ_FLAGS, 32'h20, AXI_OKAY);
    waveform_mode_field_in <= WGM_CTC_CAPT;
    counter_value_in <= 16'h7777;
    comparator_in <= 1'b0;
    cyc(1);
    comparator_in <= 1'b1;
    cyc(3);
    chk(32'(capture_is_top_out), 32'h1);
    chk(32'(capture_top_out), 32'h4242);
    rchk(ADDR_IRQ_FLAGS, 32'h0, AXI_OKAY);
    top_reached_in <= 1'b1;
    cyc(1);
    top_reached_in <= 1'b0;
    cyc(3);
    rchk(ADDR_IRQ_FLAGS, 32'h20, AXI_OKAY);
    $display("test capture done");
    test_done();
  end

  // cut a hang short
  initial begin
    cyc(20000);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
